/* File: core/pds_pkg.sv */
// Shared constants, types and decode functions for the regulator shutdown sequencer
package pds_pkg;
    // Regulator slots: 0 buck one, 1 buck two, 2 buck three, 3..5 linear one..three,
    // 6 memory reference
    localparam int NUM_REG = 7;
    localparam int ORDER_W = 3;
    localparam int SLOT_W = 3;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_BUCK_ONE = 8'h5f;
    localparam logic [7:0] IDX_BUCK_TWO = 8'h60;
    localparam logic [7:0] IDX_BUCK_THREE = 8'h61;
    localparam logic [7:0] IDX_LINEAR_ONE = 8'h62;
    localparam logic [7:0] IDX_LINEAR_TWO = 8'h63;
    localparam logic [7:0] IDX_LINEAR_THREE = 8'h64;
    localparam logic [7:0] IDX_MEMORY_REF = 8'h65;
    localparam logic [7:0] IDX_CONTROL = 8'h70;
    localparam logic [7:0] IDX_STATUS = 8'h71;
    localparam int ADDR_W = 10;
    localparam int IDX_LSB = 2;

    // Field layout and reset values
    localparam int ORDER_LSB = 0;
    localparam logic [ORDER_W-1:0] ORDER_RESET = 3'h0;
    localparam int CTRL_SHUTDOWN_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_OFF_BIT = 9;
    localparam int STAT_LOADED_BIT = 10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Step spacing: least time, rounded up to whole cycles
    localparam int CLOCK_HZ = 10_000_000;
    localparam int STEP_DELAY_US = 100;
    localparam int STEP_CYCLES = (STEP_DELAY_US * CLOCK_HZ + 999_999) / 1_000_000;
    localparam int STEP_CNT_W = 10;
    localparam logic [STEP_CNT_W-1:0] STEP_LAST = 10'(STEP_CYCLES - 1);

    typedef enum logic [3:0] {
        ST_ON = 4'h1,
        ST_ALL_OFF = 4'h2,
        ST_STEP = 4'h4,
        ST_OFF = 4'h8
    } pds_state_t;

    typedef logic [NUM_REG-1:0][ORDER_W-1:0] pds_orders_t;

    // Maps a register index to {hit, slot}
    function automatic logic [SLOT_W:0] pds_slot(input logic [7:0] idx);
        case (idx)
            IDX_BUCK_ONE: pds_slot = 4'h8;
            IDX_BUCK_TWO: pds_slot = 4'h9;
            IDX_BUCK_THREE: pds_slot = 4'ha;
            IDX_LINEAR_ONE: pds_slot = 4'hb;
            IDX_LINEAR_TWO: pds_slot = 4'hc;
            IDX_LINEAR_THREE: pds_slot = 4'hd;
            IDX_MEMORY_REF: pds_slot = 4'he;
            default: pds_slot = 4'h0;
        endcase
    endfunction

    // Highest order below limit among all regulators, as {found, value}
    function automatic logic [ORDER_W:0] pds_highest_below(input pds_orders_t ord,
                                                            input logic [ORDER_W:0] limit);
        logic [ORDER_W:0] best;
        best = 4'h0;
        for (int i = 0; i < NUM_REG; i++) begin
            if ({1'b0, ord[i]} < limit && (best[ORDER_W] == 1'b0 || ord[i] > best[ORDER_W-1:0]))
                best = {1'b1, ord[i]};
        end
        pds_highest_below = best;
    endfunction
endpackage

/* File: core/pds_step_timer.sv */
// Step spacing timer: one-cycle tick every step period while running
`timescale 1ns/1ns
`default_nettype none
module pds_step_timer
    import pds_pkg::*;
(
    input wire logic mclk,   // System clock
    input wire logic reset,  // Async reset, active high
    input wire logic run,    // Count while high, clear when low
    output logic tick        // One-cycle pulse at end of each period
);
    logic [STEP_CNT_W-1:0] count;
    logic [STEP_CNT_W-1:0] next_count;

    // Wraps at the last count so successive steps stay evenly spaced
    always_comb begin
        if (!run || count == STEP_LAST) begin
            next_count = '0;
        end else begin
            next_count = count + 10'h001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign tick = run && count == STEP_LAST;
endmodule
`default_nettype wire

/* File: core/pds_sequencer.sv */
// Regulator shutdown sequencer with AXI4-Lite order registers
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pds_sequencer
    import pds_pkg::*;
(
    input wire logic mclk,                               // System clock, 10 MHz
    input wire logic reset,                              // Async reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr,          // Write address
    input wire logic s_axi_awvalid,                      // Write address valid
    output logic s_axi_awready,                          // Write address ready
    input wire logic [31:0] s_axi_wdata,                 // Write data
    input wire logic [3:0] s_axi_wstrb,                  // Write byte strobes
    input wire logic s_axi_wvalid,                       // Write data valid
    output logic s_axi_wready,                           // Write data ready
    output logic [1:0] s_axi_bresp,                      // Write response
    output logic s_axi_bvalid,                           // Write response valid
    input wire logic s_axi_bready,                       // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr,          // Read address
    input wire logic s_axi_arvalid,                      // Read address valid
    output logic s_axi_arready,                          // Read address ready
    output logic [31:0] s_axi_rdata,                     // Read data
    output logic [1:0] s_axi_rresp,                      // Read response
    output logic s_axi_rvalid,                           // Read data valid
    input wire logic s_axi_rready,                       // Read data ready
    input wire pds_orders_t fused_startup_order,         // One-time-programmed start-up order
    input wire pds_orders_t test_configuration_substitute, // Test substitute start-up order
    input wire logic test_select,                        // Use test substitute when high
    input wire logic shutdown_trigger,                   // Pulse: begin shutdown
    input wire logic restart,                            // Pulse: re-enable all when off
    output logic [NUM_REG-1:0] regulator_enable,         // Regulator on controls
    output logic sequencer_busy,                         // Shutdown in progress
    output logic all_off                                 // All regulators are off
);
    pds_state_t state;
    pds_state_t next_state;
    pds_orders_t order;
    pds_orders_t next_order;
    logic loaded;
    logic [ORDER_W-1:0] level;
    logic [ORDER_W-1:0] next_level;
    logic [NUM_REG-1:0] next_enable;
    logic step_tick;
    logic step_run;

    // Write and read channel state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_idx;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;

    logic do_write;
    logic [SLOT_W:0] wr_slot;
    logic [SLOT_W:0] rd_slot;
    logic sw_shutdown;
    logic sw_restart;
    logic [ORDER_W:0] top;
    logic [ORDER_W:0] below;
    logic [NUM_REG-1:0] level_match;

    pds_step_timer u_step_timer (
        .mclk(mclk),
        .reset(reset),
        .run(step_run),
        .tick(step_tick)
    );

    assign step_run = (state == ST_STEP);

    // Address and data are taken in either order; response once both are held
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_slot = pds_slot(aw_idx);
    assign rd_slot = pds_slot(s_axi_araddr[IDX_LSB +: 8]);
    assign sw_shutdown = do_write && aw_idx == IDX_CONTROL && w_strb[0]
                         && w_data[CTRL_SHUTDOWN_BIT];
    assign sw_restart = do_write && aw_idx == IDX_CONTROL && w_strb[0]
                        && w_data[CTRL_RESTART_BIT];

    // Bus channel next values
    always_comb begin
        next_aw_held = aw_held;
        next_aw_idx = aw_idx;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_idx = s_axi_awaddr[IDX_LSB +: 8];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // Status is read-only and unmapped indexes answer with an error
            if (wr_slot[SLOT_W] || aw_idx == IDX_CONTROL) begin
                next_bresp = RESP_OKAY;
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            if (rd_slot[SLOT_W]) begin
                next_rdata[ORDER_LSB +: ORDER_W] = order[rd_slot[SLOT_W-1:0]];
            end else if (s_axi_araddr[IDX_LSB +: 8] == IDX_STATUS) begin
                next_rdata[NUM_REG-1:0] = regulator_enable;
                next_rdata[STAT_BUSY_BIT] = sequencer_busy;
                next_rdata[STAT_OFF_BIT] = all_off;
                next_rdata[STAT_LOADED_BIT] = loaded;
            end else if (s_axi_araddr[IDX_LSB +: 8] != IDX_CONTROL) begin
                next_rresp = RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            aw_idx <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            aw_idx <= next_aw_idx;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // Order fields: fused values, or the test substitute when test_select is high, are copied in the first cycle after reset release,
    // since an async reset may only load a constant
    always_comb begin
        next_order = order;
        if (!loaded) begin
            next_order = test_select ? test_configuration_substitute
                                     : fused_startup_order;
        end else if (do_write && wr_slot[SLOT_W] && w_strb[0] && state == ST_ON) begin
            // Writes outside the on state are acknowledged but dropped
            next_order[wr_slot[SLOT_W-1:0]] = w_data[ORDER_LSB +: ORDER_W];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            order <= {NUM_REG{ORDER_RESET}};
            loaded <= 1'b0;
        end else begin
            order <= next_order;
            loaded <= 1'b1;
        end
    end

    // Regulators that belong to the current step
    generate
        for (genvar g = 0; g < NUM_REG; g++) begin : g_match
            assign level_match[g] = (order[g] == next_level);
        end
    endgenerate

    assign top = pds_highest_below(order, 4'h8);
    assign below = pds_highest_below(order, {1'b0, level});

    // Sequencer next values; orders are frozen while it runs, so the step
    // plan cannot shift under it
    always_comb begin
        next_state = state;
        next_level = level;
        next_enable = regulator_enable;
        case (state)
            ST_ON: begin
                if (loaded && (shutdown_trigger || sw_shutdown)) begin
                    if (top[ORDER_W-1:0] == ORDER_RESET) begin
                        next_state = ST_ALL_OFF;
                    end else begin
                        next_state = ST_STEP;
                        next_level = top[ORDER_W-1:0];
                    end
                end
            end
            ST_ALL_OFF: begin
                next_enable = '0;
                next_state = ST_OFF;
            end
            ST_STEP: begin
                if (step_tick) begin
                    if (below[ORDER_W]) begin
                        next_level = below[ORDER_W-1:0];
                    end else begin
                        next_state = ST_OFF;
                    end
                end
            end
            ST_OFF: begin
                if (restart || sw_restart) begin
                    next_state = ST_ON;
                end
            end
            default: begin
                next_state = ST_OFF;
                next_enable = '0;
            end
        endcase
        if (next_state == ST_STEP) begin
            next_enable = regulator_enable & ~level_match;
        end else if (next_state == ST_ON) begin
            next_enable = '1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= ST_ON;
            level <= ORDER_RESET;
            regulator_enable <= '1;
        end else begin
            state <= next_state;
            level <= next_level;
            regulator_enable <= next_enable;
        end
    end

    assign sequencer_busy = (state == ST_STEP) || (state == ST_ALL_OFF);
    assign all_off = (state == ST_OFF);
endmodule
`default_nettype wire

/* File: tb/pds_checker_asserts.sv */
// Property checker for the shutdown sequencer ports
`timescale 1ns/1ns
`default_nettype none
module pds_checker
    import pds_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic reset, // Async reset
    input wire logic [pds_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wready, // Write data ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic restart, // Restart pulse
    input wire logic [pds_pkg::NUM_REG-1:0] regulator_enable, // Enables
    input wire logic sequencer_busy, // Shutdown running
    input wire logic all_off // Everything off
);
    import pds_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [7:0] rd_idx;
    logic [7:0] next_rd_idx;
    // Remember the index of the read in flight
    always_comb begin
        next_rd_idx = rd_idx;
        if (s_axi_arvalid && s_axi_arready)
            next_rd_idx = s_axi_araddr[9:2];
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            rd_idx <= 8'h00;
        else
            rd_idx <= next_rd_idx;
    end
    // Responses stand until taken
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_arrdy; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_arrdy: assert property (p_arrdy) else $error("read not answered");
    property p_bblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_bblock: assert property (p_bblock) else $error("write taken while answering");
    // Order fields read back with only three live bits
    property p_field; s_axi_rvalid && rd_idx >= IDX_BUCK_ONE && rd_idx <= IDX_MEMORY_REF
        |-> s_axi_rdata[31:3] == 29'h0; endproperty
    a_field: assert property (p_field) else $error("order field too wide");
    property p_norise; sequencer_busy |=> (regulator_enable & ~$past(regulator_enable)) == 7'h00;
    endproperty
    a_norise: assert property (p_norise) else $error("regulator re-enabled in shutdown");
    property p_steady; sequencer_busy && $changed(regulator_enable)
        |=> $stable(regulator_enable) [*8]; endproperty
    a_steady: assert property (p_steady) else $error("steps too close");
    property p_off; all_off |-> regulator_enable == 7'h00 && !sequencer_busy; endproperty
    a_off: assert property (p_off) else $error("off state with regulator on");
    property p_restart; all_off && restart |=> regulator_enable == 7'h7f && !all_off; endproperty
    a_restart: assert property (p_restart) else $error("restart not honoured");
endmodule
bind pds_sequencer pds_checker chk (.mclk, .reset, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .restart, .regulator_enable, .sequencer_busy,
    .all_off);
`default_nettype wire

/* File: tb/pds_host_model.sv */
// Host processor model: AXI4-Lite master reaching the order registers
`timescale 1ns/1ns
`default_nettype none
module pds_host_model
    import pds_pkg::*;
(
    input wire logic mclk, // Clock
    output logic [pds_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    output logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    output logic [31:0] s_axi_wdata, // Write data
    output logic [3:0] s_axi_wstrb, // Byte strobes
    output logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // Response valid
    output logic s_axi_bready, // Response ready
    output logic [pds_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    output logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read valid
    output logic s_axi_rready // Read ready
);
    import pds_pkg::*;
    // Idle bus at time zero; whole words only
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // One write; address and data each held until taken
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] resp);
        logic a_done;
        logic w_done;
        @(posedge mclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        a_done = 1'b0;
        w_done = 1'b0;
        while (!(a_done && w_done)) begin
            @(posedge mclk);
            a_done = a_done || (s_axi_awvalid && s_axi_awready);
            w_done = w_done || (s_axi_wvalid && s_axi_wready);
            s_axi_awvalid <= s_axi_awvalid && !a_done;
            s_axi_wvalid <= s_axi_wvalid && !w_done;
        end
        // Ready only once the answer stands, so a held response is exercised
        do @(posedge mclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge mclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // One read; no latency assumed, the bench timeout bounds a hang
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        @(posedge mclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge mclk);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the regulator shutdown sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pds_pkg::*;
    logic mclk = 1'b0;
    logic reset;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    pds_orders_t fused, subst;
    logic test_select, shutdown_trigger, restart, sequencer_busy, all_off;
    logic [NUM_REG-1:0] regulator_enable;
    logic [6:0] steps [4] = '{7'h7e, 7'h7a, 7'h78, 7'h00};
    int bad_count, comparisons, cycles, n;
    pds_sequencer uut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fused_startup_order(fused),
        .test_configuration_substitute(subst), .test_select, .shutdown_trigger, .restart,
        .regulator_enable, .sequencer_busy, .all_off);
    pds_host_model host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    // 100 ns clock and a hang limit well above the run length
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("%0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Two edges after release so the trigger is honoured
    task automatic do_reset();
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        host.rd(idx, rd, resp);
        check(rd, exp);
        check(32'(resp), 32'(RESP_OKAY));
    endtask
    // Enables are looked at mid-cycle, clear of the edge
    task automatic en_is(input logic [6:0] exp);
        @(negedge mclk);
        check(32'(regulator_enable), 32'(exp));
    endtask
    initial begin
        reset = 1'b1;
        {shutdown_trigger, restart, test_select} = 3'h0;
        {bad_count, comparisons, cycles} = '0;
        fused = '0;
        fused[0] = 3'h2;
        fused[1] = 3'h1;
        fused[2] = 3'h2;
        subst = '0;
        subst[1] = 3'h6;
        do_reset();
        for (int i = 0; i < NUM_REG; i++)
            rdchk(IDX_BUCK_ONE + 8'(i), 32'(fused[i]));
        rdchk(IDX_STATUS, 32'h47f);
        $display("test reset_load done");
        // Upper bits of a write fall away; an unmapped index is refused
        host.wr(IDX_BUCK_ONE, 32'hffff_fffd, resp);
        check(32'(resp), 32'(RESP_OKAY));
        rdchk(IDX_BUCK_ONE, 32'h5);
        host.wr(8'h50, 32'h1, resp);
        check(32'(resp), 32'(RESP_SLVERR));
        // Stepped shutdown with the rewritten order, levels 5, 2, 1, 0
        shutdown_trigger <= 1'b1;
        @(posedge mclk);
        shutdown_trigger <= 1'b0;
        // Each step lands exactly one step period after the one before
        for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
                repeat (STEP_CYCLES - 1) @(posedge mclk);
                en_is(steps[k - 1]);
            end
            en_is(steps[k]);
            check(32'(sequencer_busy), 32'h1);
        end
        repeat (STEP_CYCLES) @(posedge mclk);
        @(negedge mclk);
        check(32'({all_off, sequencer_busy}), 32'h2);
        host.wr(IDX_BUCK_TWO, 32'h3, resp);
        rdchk(IDX_BUCK_TWO, 32'h1);
        restart <= 1'b1;
        @(posedge mclk);
        restart <= 1'b0;
        en_is(7'h7f);
        $display("test stepped done");
        // All fields zero: everything drops together, started through control
        for (int i = 0; i < NUM_REG; i++)
            host.wr(IDX_BUCK_ONE + 8'(i), 32'h0, resp);
        host.wr(IDX_CONTROL, 32'h1, resp);
        n = 0;
        while (!all_off && n < 10) begin
            @(negedge mclk);
            n++;
        end
        check(32'({all_off, regulator_enable}), 32'h80);
        host.wr(IDX_CONTROL, 32'h2, resp);
        en_is(7'h7f);
        $display("test all_zero done");
        // Reset reloads the start-up source, never the written values
        test_select <= 1'b1;
        do_reset();
        for (int i = 0; i < NUM_REG; i++)
            rdchk(IDX_BUCK_ONE + 8'(i), 32'(subst[i]));
        test_select <= 1'b0;
        do_reset();
        rdchk(IDX_BUCK_ONE, 32'h2);
        $display("test reload done");
        complete_run();
    end
endmodule
`default_nettype wire
